// ---- hw/sfhp_top.sv ----
`timescale 1ns/1ps
module sfhp_top
  import sfhp_pkg::*;
#(
  parameter int DW    = 16,
  parameter int DEPTH = 16
) (
  // Core clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst_b,
  // Register port
  input  wire logic [sfhp_pkg::REG_AW-1:0] reg_addr,
  input  wire logic [sfhp_pkg::REG_DW-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [sfhp_pkg::REG_DW-1:0] reg_rdata,
  // Interface clock
  input  wire logic                       interface_clock_pin,
  output logic                            interface_clock_pin_out,
  output logic                            interface_clock_pin_oe,
  // Data bus
  input  wire logic [DW-1:0]              shared_data_lines_in,
  output logic      [DW-1:0]              shared_data_lines_out,
  output logic      [1:0]                 shared_data_lines_oe,
  // Buffer control
  input  wire logic [2:0]                 buffer_select_inputs,
  input  wire logic                       buffer_read_strobe,
  input  wire logic                       buffer_write_strobe,
  input  wire logic                       buffer_output_enable,
  input  wire logic                       packet_commit_input,
  // Status pins
  output logic                            status_pin_first,
  output logic                            status_pin_second,
  output logic                            status_pin_third,
  input  wire logic                       status_pin_fourth_in,
  output logic                            status_pin_fourth_out,
  output logic                            status_pin_fourth_oe
);
  import sfhp_pkg::*;

  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;
  localparam int SW = 34;

  function automatic logic flag_pick(input logic [1:0] src,
                                     input logic lvl, input logic full,
                                     input logic empty);
    case (sfhp_fsrc_t'(src))
      FSRC_LEVEL: flag_pick = lvl;
      FSRC_FULL:  flag_pick = full;
      FSRC_EMPTY: flag_pick = empty;
      default:    flag_pick = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Core registers
  logic [7:0] ifcfg_reg, polarity_config_register_reg, flagsel_reg, mode_reg;
  logic [7:0] pf_level_reg, cmd_resp_reg, cmd_last_reg, commits_reg;
  logic [2:0] cmd_tgl_sync, cmt_tgl_sync;
  logic [7:0] cmd_byte_reg;
  logic       cmd_tgl_reg, cmt_tgl_reg;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ifcfg_reg    <= IFCFG_RST;
      polarity_config_register_reg    <= POLARITY_CONFIG_REGISTER_RST;
      flagsel_reg  <= FLAGSEL_RST;
      mode_reg     <= MODE_RST;
      pf_level_reg <= PF_RST;
      cmd_resp_reg <= RESP_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        REG_IFCFG:    ifcfg_reg    <= reg_wdata;
        REG_POLARITY_CONFIG_REGISTER:    polarity_config_register_reg    <= reg_wdata;
        REG_FLAGSEL:  flagsel_reg  <= reg_wdata;
        REG_MODE:     mode_reg     <= reg_wdata;
        REG_PF_LEVEL: pf_level_reg <= reg_wdata;
        REG_CMD_RESP: cmd_resp_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_IFCFG:    reg_rdata <= ifcfg_reg;
        REG_POLARITY_CONFIG_REGISTER:    reg_rdata <= polarity_config_register_reg;
        REG_FLAGSEL:  reg_rdata <= flagsel_reg;
        REG_MODE:     reg_rdata <= mode_reg;
        REG_PF_LEVEL: reg_rdata <= pf_level_reg;
        REG_CMD_RESP: reg_rdata <= cmd_resp_reg;
        REG_CMD_LAST: reg_rdata <= cmd_last_reg;
        default:      reg_rdata <= commits_reg;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Toggle crossings back from the link; stage 0 feeds stage 1 only
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cmd_tgl_sync <= 3'h0;
      cmt_tgl_sync <= 3'h0;
    end else begin
      cmd_tgl_sync <= {cmd_tgl_sync[1:0], cmd_tgl_reg};
      cmt_tgl_sync <= {cmt_tgl_sync[1:0], cmt_tgl_reg};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cmd_last_reg <= 8'h00;
    end else if (cmd_tgl_sync[2] != cmd_tgl_sync[1]) begin
      cmd_last_reg <= cmd_byte_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      commits_reg <= 8'h00;
    end else if (cmt_tgl_sync[2] != cmt_tgl_sync[1]) begin
      commits_reg <= commits_reg + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interface clock generation
  logic [7:0] div_cnt_reg;
  logic       div_clk_reg;
  logic [7:0] div_half;

  assign div_half = ifcfg_reg[IFCFG_48_BIT] ? 8'(HALF_FAST_CYC)
                                            : 8'(HALF_SLOW_CYC);

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      div_cnt_reg <= 8'h00;
      div_clk_reg <= 1'b0;
    end else if (div_cnt_reg >= div_half - 8'h01) begin
      div_cnt_reg <= 8'h00;
      div_clk_reg <= ~div_clk_reg;
    end else begin
      div_cnt_reg <= div_cnt_reg + 8'h01;
    end
  end

  assign interface_clock_pin_out = div_clk_reg ^ ifcfg_reg[IFCFG_INV_BIT];
  assign interface_clock_pin_oe  = ifcfg_reg[IFCFG_INT_BIT]
                   & ifcfg_reg[IFCFG_OE_BIT];

  // Quasi-static select bit: change it only while the link is idle
  logic xfer_clk;
  assign xfer_clk = interface_clock_pin ^ ifcfg_reg[IFCFG_INV_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: reset and configuration crossing
  logic [1:0]    lrst_sync;
  logic          link_rst_b;
  logic [SW-1:0] cfg_s0, cfg_s1;

  always_ff @(posedge xfer_clk) begin
    lrst_sync <= {lrst_sync[0], rst_b};
  end
  assign link_rst_b = lrst_sync[1];

  always_ff @(posedge xfer_clk) begin
    cfg_s0 <= {polarity_config_register_reg, flagsel_reg, mode_reg[1:0], pf_level_reg,
               cmd_resp_reg};
    cfg_s1 <= cfg_s0;
  end

  logic [7:0] pol_s, fsel_s, lvl_s, resp_s;
  logic [1:0] mode_s;
  assign {pol_s, fsel_s, mode_s, lvl_s, resp_s} = cfg_s1;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: pin decode
  logic cs_act, rd_act, wr_act, oe_act, pkt_act, is_cmd, is_buf, wide;
  logic [1:0] bsel;

  assign wide   = mode_s[MODE_WIDE_BIT];
  assign cs_act = mode_s[MODE_STATUS_PIN_FOURTH_BIT] | ~status_pin_fourth_in;
  assign rd_act = buffer_read_strobe   == pol_s[POL_RD_BIT];
  assign wr_act = buffer_write_strobe  == pol_s[POL_WR_BIT];
  assign oe_act = buffer_output_enable == pol_s[POL_OE_BIT];
  assign pkt_act = packet_commit_input == pol_s[POL_PKT_BIT];
  assign is_cmd = buffer_select_inputs == CMD_SEL;
  assign is_buf = ~buffer_select_inputs[2];
  assign bsel   = buffer_select_inputs[1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: buffer pointers
  logic [PW-1:0] wr_ptr_reg [NBUF];
  logic [PW-1:0] rd_ptr_reg [NBUF];
  logic [CW-1:0] cnt_reg    [NBUF];
  logic          sel_full, sel_empty, sel_lvl, wr_go, rd_go;
  logic [PW-1:0] rd_ptr_next;
  logic [DW-1:0] mem_rdata, mem_wdata;

  assign sel_full  = cnt_reg[bsel] == CW'(DEPTH);
  assign sel_empty = cnt_reg[bsel] == '0;
  assign sel_lvl   = {{(8-CW){1'b0}}, cnt_reg[bsel]} >= lvl_s;
  assign wr_go = cs_act & wr_act & is_buf & ~sel_full;
  assign rd_go = cs_act & rd_act & is_buf & ~sel_empty;
  assign rd_ptr_next = rd_go ? rd_ptr_reg[bsel] + PW'(1) : rd_ptr_reg[bsel];
  assign mem_wdata = wide ? shared_data_lines_in
                          : {{(DW-8){1'b0}}, shared_data_lines_in[7:0]};

  always_ff @(posedge xfer_clk) begin
    if (!link_rst_b) begin
      for (int i = 0; i < NBUF; i++) begin
        wr_ptr_reg[i] <= '0;
        rd_ptr_reg[i] <= '0;
        cnt_reg[i]    <= '0;
      end
    end else begin
      if (wr_go) begin
        wr_ptr_reg[bsel] <= wr_ptr_reg[bsel] + PW'(1);
      end
      if (rd_go) begin
        rd_ptr_reg[bsel] <= rd_ptr_next;
      end
      if (wr_go && !rd_go) begin
        cnt_reg[bsel] <= cnt_reg[bsel] + CW'(1);
      end else if (rd_go && !wr_go) begin
        cnt_reg[bsel] <= cnt_reg[bsel] - CW'(1);
      end
    end
  end

  sfhp_mem #(
    .W  (DW),
    .AW (PW + 2)
  ) u_mem (
    .clk     (xfer_clk),
    .wr_en   (wr_go),
    .wr_addr ({bsel, wr_ptr_reg[bsel]}),
    .wr_data (mem_wdata),
    .rd_addr ({bsel, rd_ptr_next}),
    .rd_data (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: command port and packet commit
  logic pkt_prev_reg, cmd_out_reg;

  always_ff @(posedge xfer_clk) begin
    if (!link_rst_b) begin
      cmd_byte_reg <= 8'h00;
      cmd_tgl_reg  <= 1'b0;
    end else if (cs_act && wr_act && is_cmd) begin
      cmd_byte_reg <= shared_data_lines_in[7:0];
      cmd_tgl_reg  <= ~cmd_tgl_reg;
    end
  end

  always_ff @(posedge xfer_clk) begin
    if (!link_rst_b) begin
      pkt_prev_reg <= 1'b0;
      cmt_tgl_reg  <= 1'b0;
    end else begin
      pkt_prev_reg <= pkt_act;
      if (pkt_act && !pkt_prev_reg && cs_act && is_buf) begin
        cmt_tgl_reg <= ~cmt_tgl_reg;
      end
    end
  end

  always_ff @(posedge xfer_clk) begin
    if (!link_rst_b) begin
      cmd_out_reg <= 1'b0;
    end else begin
      cmd_out_reg <= is_cmd;
    end
  end

  // Command bytes use the low lane only
  assign shared_data_lines_out = cmd_out_reg ? {{(DW-8){1'b0}}, resp_s}
                                             : mem_rdata;
  assign shared_data_lines_oe = {cs_act & oe_act & wide & ~is_cmd,
                                 cs_act & oe_act};

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: status pins, active low, high from reset
  logic flag_d_reg;

  always_ff @(posedge xfer_clk) begin
    if (!link_rst_b) begin
      status_pin_first  <= 1'b1;
      status_pin_second <= 1'b1;
      status_pin_third  <= 1'b1;
      flag_d_reg        <= 1'b1;
    end else begin
      status_pin_first  <= ~flag_pick(fsel_s[FSEL_A_LSB +: 2], sel_lvl,
                                      sel_full, sel_empty);
      status_pin_second <= ~flag_pick(fsel_s[FSEL_B_LSB +: 2], sel_lvl,
                                      sel_full, sel_empty);
      status_pin_third  <= ~flag_pick(fsel_s[FSEL_C_LSB +: 2], sel_lvl,
                                      sel_full, sel_empty);
      flag_d_reg        <= ~flag_pick(fsel_s[FSEL_D_LSB +: 2], sel_lvl,
                                      sel_full, sel_empty);
    end
  end

  assign status_pin_fourth_out = flag_d_reg;
  assign status_pin_fourth_oe  = mode_s[MODE_STATUS_PIN_FOURTH_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge xfer_clk); endclocking
  default disable iff (!link_rst_b);

  AST_BUS_RELEASED: assert property (
    !(cs_act && oe_act) |-> shared_data_lines_oe == 2'b00)
    else $error("data bus driven without select and enable");
  AST_HIGH_LANE: assert property (
    shared_data_lines_oe[1] |-> wide && !is_cmd && shared_data_lines_oe[0])
    else $error("high lane driven outside 16-bit buffer access");
  AST_CMD_LOW: assert property (
    cmd_out_reg |-> shared_data_lines_out[DW-1:8] == '0)
    else $error("command byte leaks onto high lane");
  AST_POP: assert property (
    rd_go && !wr_go |=> cnt_reg[$past(bsel)] == $past(cnt_reg[bsel]) - 1)
    else $error("read strobe did not pop the buffer");
  AST_PUSH: assert property (
    wr_go && !rd_go |=> cnt_reg[$past(bsel)] == $past(cnt_reg[bsel]) + 1)
    else $error("write strobe did not push the buffer");
  AST_FULL_HOLD: assert property (
    sel_full && !rd_go |=> cnt_reg[$past(bsel)] == CW'(DEPTH))
    else $error("write accepted into a full buffer");
  AST_FLAG_RESET: assert property (
    disable iff (1'b0) !link_rst_b |=> status_pin_first && status_pin_second
                                      && status_pin_third)
    else $error("status pins not high after reset");
  AST_FLAG_LEVEL: assert property (
    fsel_s[FSEL_A_LSB +: 2] == 2'h0 && $stable(fsel_s) |=>
      status_pin_first == !$past(sel_lvl))
    else $error("first status pin does not follow the level flag");
  AST_FLAG_FULL: assert property (
    fsel_s[FSEL_B_LSB +: 2] == 2'h1 && $stable(fsel_s) |=>
      status_pin_second == !$past(sel_full))
    else $error("second status pin does not follow full");
  AST_FLAG_EMPTY: assert property (
    fsel_s[FSEL_C_LSB +: 2] == 2'h2 && $stable(fsel_s) |=>
      status_pin_third == !$past(sel_empty))
    else $error("third status pin does not follow empty");
  AST_COMMIT: assert property (
    pkt_act && pkt_prev_reg |=> cmt_tgl_reg == $past(cmt_tgl_reg))
    else $error("held packet end committed more than once");

  COV_PUSH_POP: cover property (wr_go ##[1:20] rd_go);
  COV_FULL:     cover property (sel_full);
  COV_CMD:      cover property (cs_act && wr_act && is_cmd);
  COV_COMMIT:   cover property (cmt_tgl_reg != $past(cmt_tgl_reg));

endmodule

// ---- hw/sfhp_pkg.sv ----
package sfhp_pkg;

  // Register port
  localparam int          REG_AW        = 3;
  localparam int          REG_DW        = 8;
  localparam logic [2:0]  REG_IFCFG     = 3'h0;
  localparam logic [2:0]  REG_POLARITY_CONFIG_REGISTER     = 3'h1;
  localparam logic [2:0]  REG_FLAGSEL   = 3'h2;
  localparam logic [2:0]  REG_MODE      = 3'h3;
  localparam logic [2:0]  REG_PF_LEVEL  = 3'h4;
  localparam logic [2:0]  REG_CMD_RESP  = 3'h5;
  localparam logic [2:0]  REG_CMD_LAST  = 3'h6;
  localparam logic [2:0]  REG_COMMITS   = 3'h7;

  // Interface configuration fields
  localparam int IFCFG_INV_BIT  = 4;
  localparam int IFCFG_OE_BIT   = 5;
  localparam int IFCFG_48_BIT   = 6;
  localparam int IFCFG_INT_BIT  = 7;

  // Polarity fields: bit set means the pin is active high
  localparam int POL_WR_BIT     = 2;
  localparam int POL_RD_BIT     = 3;
  localparam int POL_OE_BIT     = 4;
  localparam int POL_PKT_BIT    = 5;

  // Link mode fields
  localparam int MODE_WIDE_BIT  = 0;
  localparam int MODE_STATUS_PIN_FOURTH_BIT = 1;

  // Flag select fields, two bits per status pin
  localparam int FSEL_A_LSB     = 0;
  localparam int FSEL_B_LSB     = 2;
  localparam int FSEL_C_LSB     = 4;
  localparam int FSEL_D_LSB     = 6;

  // Reset values
  localparam logic [7:0] IFCFG_RST   = 8'h00;
  localparam logic [7:0] POLARITY_CONFIG_REGISTER_RST   = 8'h00;
  localparam logic [7:0] FLAGSEL_RST = 8'h24;
  localparam logic [7:0] MODE_RST    = 8'h01;
  localparam logic [7:0] PF_RST      = 8'h08;
  localparam logic [7:0] RESP_RST    = 8'h00;

  // Buffer select code that reaches the command interface
  localparam logic [2:0] CMD_SEL     = 3'h4;
  localparam int         NBUF        = 4;

  // Interface clock generation
  localparam int CLK_MHZ        = 100;
  localparam int INTERFACE_CLOCK_PIN_SLOW_MHZ = 30;
  localparam int INTERFACE_CLOCK_PIN_FAST_MHZ = 48;
  localparam int HALF_SLOW_CYC  =
    (CLK_MHZ + 2 * INTERFACE_CLOCK_PIN_SLOW_MHZ - 1) / (2 * INTERFACE_CLOCK_PIN_SLOW_MHZ);
  localparam int HALF_FAST_CYC  =
    (CLK_MHZ + 2 * INTERFACE_CLOCK_PIN_FAST_MHZ - 1) / (2 * INTERFACE_CLOCK_PIN_FAST_MHZ);

  typedef enum logic [1:0] {
    FSRC_LEVEL,
    FSRC_FULL,
    FSRC_EMPTY,
    FSRC_IDLE
  } sfhp_fsrc_t;

endpackage

// ---- hw/sfhp_mem.sv ----
`timescale 1ns/1ps
module sfhp_mem #(
  parameter int W  = 16,
  parameter int AW = 6
) (
  // Clock
  input  wire logic          clk,
  // Write side
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  // Read side
  input  wire logic [AW-1:0] rd_addr,
  output logic      [W-1:0]  rd_data
);

  logic [W-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Write-first so a word pushed into an empty buffer is seen at once
  always_ff @(posedge clk) begin
    if (wr_en && (wr_addr == rd_addr)) begin
      rd_data <= wr_data;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// ---- tb/sfhp_master_model.sv ----
`timescale 1ns/1ps
module sfhp_master_model (
  // Link clock
  output logic             link_clk,
  // Pins toward the device
  output logic [15:0]      bus_to_dev,
  output logic [2:0]       sel,
  output logic             rd_pin,
  output logic             wr_pin,
  output logic             oe_pin,
  output logic             pkt_pin,
  output logic             cs_b,
  // Pins from the device
  input  wire logic [15:0] dev_out,
  input  wire logic [1:0]  dev_oe
);
  logic [7:0]  pol = 8'h00;
  logic [15:0] drv = 16'h0000;
  logic        driving = 1'b0;
  logic [15:0] last = 16'h0000;

  initial begin
    link_clk = 1'b0;
    sel = 3'h0;
    cs_b = 1'b1;
    rd_pin = 1'b1;
    wr_pin = 1'b1;
    oe_pin = 1'b1;
    pkt_pin = 1'b1;
  end

  always #62.5 link_clk = ~link_clk;

  ////////////////////////////////////////////////////////////////////////
  // Wire level per byte lane; a released lane shows a changing pattern
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (dev_oe[i]) begin
        bus_to_dev[i*8+:8] = dev_out[i*8+:8];
      end else if (driving) begin
        bus_to_dev[i*8+:8] = drv[i*8+:8];
      end else begin
        bus_to_dev[i*8+:8] = ~last[i*8+:8];
      end
    end
  end

  always @(posedge link_clk) last <= bus_to_dev;

  ////////////////////////////////////////////////////////////////////////
  task automatic idle(input int n);
    repeat (n) @(posedge link_clk);
  endtask

  task automatic set_pol(input logic [7:0] p);
    @(posedge link_clk);
    pol <= p;
    rd_pin <= ~p[3];
    wr_pin <= ~p[2];
    oe_pin <= ~p[4];
    pkt_pin <= ~p[5];
  endtask

  task automatic push(input logic [2:0] s, input logic [15:0] w);
    @(posedge link_clk);
    sel <= s;
    cs_b <= 1'b0;
    drv <= w;
    driving <= 1'b1;
    wr_pin <= pol[2];
    @(posedge link_clk);
    wr_pin <= ~pol[2];
    cs_b <= 1'b1;
    driving <= 1'b0;
  endtask

  task automatic pop(input logic [2:0] s, output logic [15:0] w,
                     output logic [1:0] o);
    @(posedge link_clk);
    sel <= s;
    cs_b <= 1'b0;
    oe_pin <= pol[4];
    @(posedge link_clk);
    rd_pin <= pol[3];
    @(negedge link_clk);
    w = bus_to_dev;
    o = dev_oe;
    @(posedge link_clk);
    rd_pin <= ~pol[3];
    oe_pin <= ~pol[4];
    cs_b <= 1'b1;
  endtask

  task automatic commit(input logic [2:0] s);
    @(posedge link_clk);
    sel <= s;
    cs_b <= 1'b0;
    pkt_pin <= pol[5];
    @(posedge link_clk);
    pkt_pin <= ~pol[5];
    cs_b <= 1'b1;
  endtask
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import sfhp_pkg::*;
  localparam int DEPTH = 16;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [2:0]  reg_addr = 3'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic        link_clk, interface_clock_pin_out, interface_clock_pin_oe, rd_p, wr_p, oe_p, pkt_p;
  logic        cs_b, fl_a, fl_b, fl_c, fl_d, fl_d_oe;
  logic [15:0] bus, dout;
  logic [1:0]  doe;
  logic [2:0]  sel;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          cyc = 0;

  always #5 ref_clk = ~ref_clk;

  sfhp_master_model m (.link_clk(link_clk), .bus_to_dev(bus), .sel(sel),
    .rd_pin(rd_p), .wr_pin(wr_p), .oe_pin(oe_p), .pkt_pin(pkt_p),
    .cs_b(cs_b), .dev_out(dout), .dev_oe(doe));

  sfhp_top #(.DW(16), .DEPTH(DEPTH)) uut (.ref_clk(ref_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .interface_clock_pin(link_clk),
    .interface_clock_pin_out(interface_clock_pin_out), .interface_clock_pin_oe(interface_clock_pin_oe), .shared_data_lines_in(bus),
    .shared_data_lines_out(dout), .shared_data_lines_oe(doe),
    .buffer_select_inputs(sel), .buffer_read_strobe(rd_p),
    .buffer_write_strobe(wr_p), .buffer_output_enable(oe_p),
    .packet_commit_input(pkt_p), .status_pin_first(fl_a),
    .status_pin_second(fl_b), .status_pin_third(fl_c),
    .status_pin_fourth_in(cs_b), .status_pin_fourth_out(fl_d),
    .status_pin_fourth_oe(fl_d_oe));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Status pins move on the link edge, so look half a link cycle later
  task automatic flags(input logic [2:0] e);
    @(negedge link_clk);
    chk({13'h0000, fl_a, fl_b, fl_c}, {13'h0000, e});
  endtask

  task automatic flag_d(input logic [1:0] e);
    @(negedge link_clk);
    chk({14'h0000, fl_d_oe, fl_d}, {14'h0000, e});
  endtask

  task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask

  task automatic reg_chk(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    reg_read(a, d);
    chk({8'h00, d}, {8'h00, e});
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] e [6];
    e = '{IFCFG_RST, POLARITY_CONFIG_REGISTER_RST, FLAGSEL_RST, MODE_RST, PF_RST, RESP_RST};
    for (int i = 0; i < 6; i++) reg_chk(3'(i), e[i]);
    flags(3'b110);
  endtask

  task automatic t_fill();
    logic [15:0] w;
    logic [1:0]  o;
    for (int i = 0; i < DEPTH; i++) begin
      m.push(3'h0, 16'ha500 + 16'(i));
      if (i == 6 || i == 7) begin
        m.idle(2);
        flags({i == 6, 2'b11});
      end
    end
    m.idle(2);
    flags(3'b001);
    m.push(3'h0, 16'hdead);
    for (int i = 0; i < DEPTH; i++) begin
      m.pop(3'h0, w, o);
      chk(w, 16'ha500 + 16'(i));
      chk({14'h0000, o}, 16'h0003);
    end
    m.idle(2);
    flags(3'b110);
    chk({14'h0000, doe}, 16'h0000);
  endtask

  task automatic t_pol();
    logic [15:0] w;
    logic [1:0]  o;
    logic [7:0]  c;
    reg_write(REG_POLARITY_CONFIG_REGISTER, 8'h3c);
    m.set_pol(8'h3c);
    m.idle(4);
    m.push(3'h1, 16'h1234);
    m.pop(3'h1, w, o);
    chk(w, 16'h1234);
    chk({14'h0000, o}, 16'h0003);
    reg_read(REG_COMMITS, c);
    chk({8'h00, c}, 16'h0000);
    m.commit(3'h1);
    m.idle(2);
    reg_chk(REG_COMMITS, 8'h01);
    reg_write(REG_COMMITS, 8'hff);
    reg_chk(REG_COMMITS, 8'h01);
    reg_write(REG_POLARITY_CONFIG_REGISTER, 8'h00);
    m.set_pol(8'h00);
    m.idle(4);
  endtask

  task automatic t_narrow();
    logic [15:0] w;
    logic [1:0]  o;
    reg_write(REG_MODE, 8'h00);
    reg_write(REG_CMD_RESP, 8'hc3);
    m.idle(4);
    m.push(3'h2, 16'hbeef);
    m.pop(3'h2, w, o);
    chk({8'h00, w[7:0]}, 16'h00ef);
    chk({14'h0000, o}, 16'h0001);
    m.push(CMD_SEL, 16'h335a);
    m.idle(3);
    reg_chk(REG_CMD_LAST, 8'h5a);
    m.pop(CMD_SEL, w, o);
    chk({8'h00, w[7:0]}, 16'h00c3);
    reg_write(REG_MODE, 8'h01);
    m.idle(4);
  endtask

  task automatic t_clk();
    int          n;
    logic        p;
    logic [15:0] w;
    logic [1:0]  o;
    logic [7:0]  cfg [3];
    cfg = '{8'ha0, 8'he0, 8'h80};
    for (int k = 0; k < 3; k++) begin
      n = 0;
      reg_write(REG_IFCFG, cfg[k]);
      repeat (4) @(negedge ref_clk);
      chk({15'h0000, interface_clock_pin_oe}, {15'h0000, cfg[k][IFCFG_OE_BIT]});
      p = interface_clock_pin_out;
      repeat (16) begin
        @(negedge ref_clk);
        n += int'(interface_clock_pin_out !== p);
        p = interface_clock_pin_out;
      end
      chk(16'(n), 16'(16 / (cfg[k][IFCFG_48_BIT] ? HALF_FAST_CYC
                                                 : HALF_SLOW_CYC)));
    end
    reg_write(REG_IFCFG, 8'h10);
    m.idle(4);
    m.push(3'h3, 16'h0f0f);
    reg_write(REG_IFCFG, 8'h00);
    m.idle(4);
    m.pop(3'h3, w, o);
    chk(w, 16'h0f0f);
  endtask

  // Shared pin as fourth flag, and the no-source code on the others
  task automatic t_status_pin_fourth();
    flag_d(2'b01);
    reg_write(REG_MODE, 8'h03);
    reg_write(REG_FLAGSEL, 8'hbf);
    m.idle(4);
    flags(3'b111);
    flag_d(2'b10);
    reg_write(REG_FLAGSEL, FLAGSEL_RST);
    reg_write(REG_MODE, MODE_RST);
    m.idle(4);
    flags(3'b110);
    flag_d(2'b01);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  initial begin
    m.idle(5);
    flags(3'b111);
    flag_d(2'b01);
    chk({15'h0000, interface_clock_pin_oe}, 16'h0000);
    @(posedge ref_clk);
    rst_b <= 1'b1;
    m.idle(3);
    t_reset();
    t_fill();
    t_pol();
    t_narrow();
    t_clk();
    t_status_pin_fourth();
    complete_run();
  end
endmodule
